// ===== bench/dpcb_ctrl_sva.sv
/* port assertions for dpcb_ctrl.
 assumes one clock and a sync active-low reset. */
`timescale 1ns/1ps
module dpcb_ctrl_sva (
	input wire sys_clk_i, // clock
	input wire rst_n_i, // reset, low
	input wire buffer_mem_select_n_o, // select
	input wire buf_we_n_o, // write
	input wire host_port_request_o, // host req
	input wire host_ack_i, // host ack
	input wire host_output_latch_strobe_o, // latch
	input wire dev_rdata_valid_o, // read pulse
	input wire target_identify_out_n_o, // target
	input wire initiator_identify_out_n_o, // initiator
	input wire cs_i, // chip select
	input wire ad_oe_o // bus drive
);
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_write_select: assert property (
		!buf_we_n_o |-> !buffer_mem_select_n_o)
		else $error("write without select");
	a_select_one: assert property (
		!buffer_mem_select_n_o |=> buffer_mem_select_n_o)
		else $error("select longer than one cycle");
	a_reset_quiet: assert property (
		$rose(rst_n_i) |-> buffer_mem_select_n_o && buf_we_n_o
		&& !host_port_request_o)
		else $error("strobes active after reset");
	a_reset_ident: assert property (
		$rose(rst_n_i) |-> target_identify_out_n_o
		&& initiator_identify_out_n_o)
		else $error("identify active after reset");
	a_read_pulse: assert property (
		dev_rdata_valid_o |=> !dev_rdata_valid_o)
		else $error("read valid longer than one cycle");
	a_latch_pulse: assert property (
		host_output_latch_strobe_o |=> !host_output_latch_strobe_o)
		else $error("latch strobe too long");
	a_bus_release: assert property (
		(!cs_i) [*4] |-> !ad_oe_o)
		else $error("bus driven without chip select");
	a_req_held: assert property (
		(!host_ack_i) [*3] ##0 host_port_request_o |=> host_port_request_o)
		else $error("host request dropped before ack");
endmodule
bind dpcb_ctrl dpcb_ctrl_sva dpcb_ctrl_sva_i (.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i), .buffer_mem_select_n_o(buffer_mem_select_n_o),
	.buf_we_n_o(buf_we_n_o), .host_port_request_o(host_port_request_o),
	.host_ack_i(host_ack_i),
	.host_output_latch_strobe_o(host_output_latch_strobe_o),
	.dev_rdata_valid_o(dev_rdata_valid_o),
	.target_identify_out_n_o(target_identify_out_n_o),
	.initiator_identify_out_n_o(initiator_identify_out_n_o),
	.cs_i(cs_i), .ad_oe_o(ad_oe_o));

// ===== bench/dpcb_far_model.sv
/* host handshake and buffer ram model.
 assumes direct addressing, data is a function of a0-a7. */
`timescale 1ns/1ps
module dpcb_far_model #(
	parameter ACK_DLY = 2
) (
	input wire sys_clk_i, // clock
	input wire req_i, // host request
	input wire ms_n_i, // ram select
	input wire [7:0] addr_i, // a0-a7
	output wire ack_o, // host ack
	output wire [7:0] rdata_o // ram data
);
	reg [7:0] flip_r = 8'h00;
	reg [3:0] dly_r = 4'h0;
	reg ack_r = 1'b0;
	always @(posedge sys_clk_i) begin
		flip_r <= ~flip_r;
		if (!req_i) begin
			ack_r <= 1'b0;
			dly_r <= 4'h0;
		end else if (dly_r == ACK_DLY) begin
			ack_r <= 1'b1;
		end else begin
			dly_r <= dly_r + 4'h1;
		end
	end
	assign ack_o = ack_r;
	// released data toggles every cycle
	assign rdata_o = !ms_n_i ? addr_i + 8'h3C : flip_r;
endmodule

// ===== bench/tb.sv
/* bench for dpcb_ctrl with far-side model.
 assumes dpcb_regs.vh on the include path. */
`timescale 1ns/1ps
`include "dpcb_regs.vh"
module tb;
	reg sys_clk_i, rst_n_i, dev_req_n_i, dv, busy_i, cs_i, ale_i;
	reg rd_n_i, wr_n_i;
	reg sel_i, ext_on;
	reg [7:0] rd_base;
	reg [7:0] wd, ad_i;
	reg [23:0] rows [0:6];
	wire rdy, rv, req, ack, lat, boe_n, ms_n, we_n, bsy, tgt_n, ini_n;
	wire done, oe, dsp, doe_n;
	wire [7:0] rd_d, addr, ram_d, ad_o;
	integer err_count, cmp_count, cyc, rd_cnt, wr_cnt, lat_cnt, n, i;
	integer hi_cnt;
	dpcb_ctrl dpcb_ctrl_i (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .dev_req_n_i(dev_req_n_i),
		.dev_wdata_valid_i(dv), .dev_wdata_i(wd), .dev_wdata_ready_o(rdy),
		.dev_rdata_o(rd_d), .dev_rdata_valid_o(rv), .host_port_request_o(req),
		.host_ack_i(ack), .host_output_latch_strobe_o(lat),
		.host_output_drive_enable_n_o(boe_n),
		.host_input_drive_enable_n_o(), .buf_addr_o(addr), .buf_addr_hi_o(),
		.host_upper_addr_strobe_o(), .device_upper_addr_strobe_o(dsp),
		.host_upper_addr_enable_n_o(), .device_upper_addr_enable_n_o(doe_n),
		.buffer_mem_select_n_o(ms_n), .buf_we_n_o(we_n), .buf_rdata_i(ram_d),
		.busy_in_sense_i(busy_i), .select_in_sense_i(sel_i), .busy_out_o(bsy),
		.select_out_o(), .target_identify_out_n_o(tgt_n),
		.initiator_identify_out_n_o(ini_n), .dma_done_o(done), .cs_i(cs_i),
		.ale_i(ale_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .ad_i(ad_i),
		.ad_o(ad_o), .ad_oe_o(oe));
	dpcb_far_model #(.ACK_DLY(3)) dpcb_far_model_i (.sys_clk_i(sys_clk_i),
		.req_i(req), .ms_n_i(ms_n), .addr_i(addr), .ack_o(ack),
		.rdata_o(ram_d));
	task chk(input [7:0] got, input [7:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("ERROR %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task tick(input integer k);
		repeat (k) @(negedge sys_clk_i);
	endtask
	task sel_addr(input [7:0] a);
		begin
			ad_i = a;
			ale_i = 1'b1;
			tick(3);
			ale_i = 1'b0;
			tick(3);
			cs_i = 1'b1;
		end
	endtask
	task reg_wr(input [7:0] a, input [7:0] d);
		begin
			sel_addr(a);
			ad_i = d;
			wr_n_i = 1'b0;
			tick(4);
			wr_n_i = 1'b1;
			tick(3);
			cs_i = 1'b0;
			tick(1);
		end
	endtask
	task reg_chk(input [7:0] a, input [7:0] exp);
		begin
			sel_addr(a);
			rd_n_i = 1'b0;
			tick(5);
			chk({7'h00, oe}, 8'h01);
			chk(ad_o, exp);
			rd_n_i = 1'b1;
			tick(3);
			cs_i = 1'b0;
			tick(1);
		end
	endtask
	task end_of_test;
		begin
			$display("errors %0d compares %0d", err_count, cmp_count);
			if (err_count == 0 && cmp_count > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	// ---------------------------------------------
	// monitors and timeout
	// ---------------------------------------------
	always @(negedge sys_clk_i) begin
		if (rv === 1'b1) begin
			chk(rd_d, rd_base + rd_cnt[7:0] + 8'h3C);
			rd_cnt = rd_cnt + 1;
		end
		if (dsp === 1'b1) begin
			chk(addr, 8'h02);
			hi_cnt = hi_cnt + 1;
		end
		if (ext_on === 1'b1 && ms_n === 1'b0)
			chk({7'h00, doe_n}, 8'h00);
		if (ms_n === 1'b0 && we_n === 1'b0)
			wr_cnt = wr_cnt + 1;
		if (lat === 1'b1)
			lat_cnt = lat_cnt + 1;
	end
	always @(posedge sys_clk_i) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			end_of_test;
		end
	end
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		{err_count, cmp_count, cyc, rd_cnt, wr_cnt, lat_cnt, n} = 0;
		hi_cnt = 0;
		{dev_req_n_i, rd_n_i, wr_n_i} = 3'h7;
		{rst_n_i, dv, busy_i, cs_i, ale_i, wd, ad_i} = 0;
		{sel_i, ext_on} = 2'b00;
		rd_base = 8'hFE;
		rows[0] = {`DPCB_A_BUFSZ, 8'hFF, 8'hFF};
		rows[1] = {`DPCB_A_RDL, 8'h3C, 8'h3C};
		rows[2] = {`DPCB_A_RDH, 8'hC3, 8'hC3};
		rows[3] = {`DPCB_A_WRL, 8'h81, 8'h81};
		rows[4] = {`DPCB_A_WRH, 8'h18, 8'h18};
		rows[5] = {`DPCB_A_STL, 8'h7E, 8'h7E};
		rows[6] = {`DPCB_A_STH, 8'hE7, 8'hE7};
		tick(4);
		rst_n_i = 1'b1;
		tick(4);
		for (i = 0; i < 7; i = i + 1) begin
			reg_chk(rows[i][23:16], `DPCB_RST_BYTE);
			reg_wr(rows[i][23:16], rows[i][15:8]);
			reg_chk(rows[i][23:16], rows[i][7:0]);
		end
		// device reads across the 256-byte wrap
		reg_wr(`DPCB_A_BUFSZ, 8'h00);
		reg_wr(`DPCB_A_RDH, 8'h00);
		reg_wr(`DPCB_A_RDL, 8'hFE);
		dev_req_n_i = 1'b0;
		for (i = 0; i < 300 && rd_cnt < 4; i = i + 1)
			tick(1);
		dev_req_n_i = 1'b1;
		tick(20);
		chk({7'h00, rd_cnt >= 4}, 8'h01);
		reg_chk(`DPCB_A_RDL, 8'hFE + rd_cnt[7:0]);
		reg_chk(`DPCB_A_RDH, 8'h00);
		// fill the fifo while the device stalls, then drain
		reg_wr(`DPCB_A_DMACON, 8'h10);
		reg_wr(`DPCB_A_WRH, 8'h00);
		reg_wr(`DPCB_A_WRL, 8'h00);
		dv = 1'b1;
		for (i = 0; i < 20; i = i + 1) begin
			wd = i[7:0];
			if (rdy === 1'b1)
				n = n + 1;
			tick(1);
		end
		dv = 1'b0;
		chk(n[7:0], 8'h10);
		wr_cnt = 0;
		dev_req_n_i = 1'b0;
		for (i = 0; i < 400 && wr_cnt < 16; i = i + 1)
			tick(1);
		dev_req_n_i = 1'b1;
		tick(20);
		chk({7'h00, wr_cnt >= 16}, 8'h01);
		reg_chk(`DPCB_A_WRL, wr_cnt[7:0]);
		// host dma upload halts at the stop address
		reg_wr(`DPCB_A_RDL, 8'h10);
		reg_wr(`DPCB_A_STH, 8'h00);
		reg_wr(`DPCB_A_STL, 8'h13);
		lat_cnt = 0;
		reg_wr(`DPCB_A_DMACON, 8'h18);
		tick(300);
		reg_chk(`DPCB_A_RDL, 8'h13);
		chk(lat_cnt[7:0], 8'h03);
		chk({6'h00, done, req}, 8'h02);
		// extended addressing: high byte first, then the access
		reg_wr(`DPCB_A_DMACON, 8'h00);
		reg_wr(`DPCB_A_BUFSZ, 8'h04);
		reg_wr(`DPCB_A_RDH, 8'h02);
		reg_wr(`DPCB_A_RDL, 8'h10);
		{rd_cnt, hi_cnt} = 0;
		rd_base = 8'h10;
		ext_on = 1'b1;
		dev_req_n_i = 1'b0;
		tick(6);
		dev_req_n_i = 1'b1;
		tick(20);
		ext_on = 1'b0;
		chk({7'h00, rd_cnt > 0}, 8'h01);
		chk(hi_cnt[7:0], rd_cnt[7:0]);
		reg_chk(`DPCB_A_RDL, 8'h10 + rd_cnt[7:0]);
		reg_chk(`DPCB_A_RDH, 8'h02);
		// arbitration waits for a free bus
		busy_i = 1'b1;
		sel_i = 1'b1;
		reg_wr(`DPCB_A_IFCON, 8'h01);
		tick(8);
		chk({7'h00, bsy}, 8'h00);
		busy_i = 1'b0;
		tick(8);
		chk({7'h00, bsy}, 8'h00);
		sel_i = 1'b0;
		tick(8);
		chk({6'h00, bsy, boe_n}, 8'h02);
		reg_wr(`DPCB_A_DMACON, 8'hC0);
		chk({6'h00, tgt_n, ini_n}, 8'h00);
		rst_n_i = 1'b0;
		tick(4);
		rst_n_i = 1'b1;
		tick(4);
		chk({6'h00, tgt_n, ini_n}, 8'h03);
		reg_chk(`DPCB_A_BUFSZ, `DPCB_RST_BYTE);
		reg_chk(`DPCB_A_RDL, `DPCB_RST_BYTE);
		end_of_test;
	end
endmodule

// ===== core/dpcb_ctrl.v
/*
 * dual port circular buffer controller: address counters, port
 * arbitration, buffer strobes, host handshake, arbitration assist and
 * the 8-bit multiplexed register port.
 * assumes sys_clk_i is the master clock (one tick per falling edge of
 * the documented clock) and the device request, host ack, bus-sense and register-port pins are asynchronous to it.
 */
`timescale 1ns/1ps
`include "dpcb_regs.vh"
module dpcb_ctrl #(
	parameter AW = 16
) (
	input wire sys_clk_i, // master clock
	input wire rst_n_i, // sync reset, low
	input wire dev_req_n_i, // device_port_request, low
	input wire dev_wdata_valid_i, // device byte to store
	input wire [7:0] dev_wdata_i, // device write byte
	output wire dev_wdata_ready_o, // device fifo room
	output reg [7:0] dev_rdata_o, // byte read for device
	output reg dev_rdata_valid_o, // pulse, read byte valid
	output reg host_port_request_o, // request to host
	input wire host_ack_i, // host acknowledge
	output reg host_output_latch_strobe_o, // latch ram output
	output wire host_output_drive_enable_n_o, // host drive, low
	output wire host_input_drive_enable_n_o, // host input, low
	output reg [7:0] buf_addr_o, // a0-a7
	output reg [3:0] buf_addr_hi_o, // a8 a9 a10 a11
	output reg host_upper_addr_strobe_o, // strobe or a8
	output reg device_upper_addr_strobe_o, // strobe or a9
	output reg host_upper_addr_enable_n_o, // enable or a12
	output reg device_upper_addr_enable_n_o, // enable or a13
	output reg buffer_mem_select_n_o, // memory select, low
	output reg buf_we_n_o, // write enable, low
	input wire [7:0] buf_rdata_i, // ram read data
	input wire busy_in_sense_i, // bus busy in
	input wire select_in_sense_i, // bus select in
	output wire busy_out_o, // busy out
	output wire select_out_o, // select out
	output wire target_identify_out_n_o, // target mode, low
	output wire initiator_identify_out_n_o, // initiator mode, low
	output wire dma_done_o, // transfer done level
	input wire cs_i, // chip select, high
	input wire ale_i, // address latch enable
	input wire rd_n_i, // read strobe, low
	input wire wr_n_i, // write strobe, low
	input wire [7:0] ad_i, // muxed_addr_data_bus in
	output reg [7:0] ad_o, // muxed_addr_data_bus out
	output wire ad_oe_o // bus drive, high
);
	// -------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------
	localparam NS = 8;
	wire [NS-1:0] raw = {dev_req_n_i, host_ack_i, busy_in_sense_i,
		select_in_sense_i, cs_i, ale_i, rd_n_i, wr_n_i};
	reg [NS-1:0] s1_r;
	reg [NS-1:0] s2_r;
	reg [7:0] ad1_r;
	reg [7:0] ad2_r;
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			// idle pin levels, so no false edge follows reset
			s1_r <= `DPCB_SYNC_IDLE;
			s2_r <= `DPCB_SYNC_IDLE;
			ad1_r <= 8'h00;
			ad2_r <= 8'h00;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			ad1_r <= ad_i;
			ad2_r <= ad1_r;
		end
	end
	wire dreq_n = s2_r[7];
	wire ack = s2_r[6];
	wire bsy_in = s2_r[5];
	wire sel_in = s2_r[4];
	wire cs = s2_r[3];
	wire ale = s2_r[2];
	wire rd_n = s2_r[1];
	wire wr_n = s2_r[0];
	reg ale_d_r;
	reg rd_d_r;
	reg wr_d_r;
	// -------------------------------------------------
	// registers
	// -------------------------------------------------
	reg [7:0] addr_r;
	reg [7:0] ifcon_r;
	reg [7:0] dmacon_r;
	reg [7:0] bufsz_r;
	reg amod_r;
	reg reset_control_register_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] stop_r;
	reg arb_seen_r;
	reg done_r;
	wire wr_pulse = cs && !wr_n && wr_d_r;
	wire rd_active = cs && !rd_n;
	wire [AW-1:0] size_last = {bufsz_r, 8'hFF};
	wire extended = amod_r ? (bufsz_r > `DPCB_DIR14_MAX)
		: (bufsz_r > `DPCB_DIR10_MAX);
	wire dir_out = dmacon_r[`DPCB_DM_DIR];
	wire up_en = dmacon_r[`DPCB_DM_RDL] && dir_out;
	wire dn_en = dmacon_r[`DPCB_DM_WRL] && !dir_out;
	wire [AW-1:0] host_ptr = dir_out ? rd_ptr_r : wr_ptr_r;
	wire at_stop = (host_ptr == stop_r);
	wire host_want = (up_en || dn_en) && !at_stop && !host_port_request_o
		&& !ack;
	// -------------------------------------------------
	// transfer engine
	// -------------------------------------------------
	localparam ST_IDLE = 2'b00;
	localparam ST_HI = 2'b01;
	localparam ST_ACC = 2'b10;
	reg [1:0] st_r;
	reg port_dev_r;
	reg dev_pend_r;
	reg [AW-1:0] acc_addr_r;
	reg acc_wr_r;
	wire ff_valid;
	wire [7:0] ff_data;
	// device fills the buffer while the host uploads, and drains it
	// while the host downloads
	wire dev_in = dir_out;
	wire dev_go = dev_pend_r && (!dev_in || ff_valid);
	wire host_go = host_want && !dev_go;
	wire go_wr = dev_go ? dev_in : !dir_out;
	wire fin = (st_r == ST_ACC);
	wire ff_pop = fin && port_dev_r && acc_wr_r;
	function [AW-1:0] bump;
		input [AW-1:0] p;
		input [AW-1:0] last;
		begin
			bump = (p == last) ? {AW{1'b0}} : p + 1'b1;
		end
	endfunction
	dpcb_fifo #(
		.W(8),
		.DEPTH(`DPCB_FIFO_DEPTH),
		.AW(`DPCB_FIFO_AW)
	) u_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(dev_wdata_valid_i),
		.in_ready_o(dev_wdata_ready_o),
		.in_data_i(dev_wdata_i),
		.out_valid_o(ff_valid),
		.out_ready_i(ff_pop),
		.out_data_o(ff_data)
	);
	reg [7:0] wdata_r;
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_r <= ST_IDLE;
			port_dev_r <= 1'b0;
			dev_pend_r <= 1'b0;
			acc_addr_r <= {AW{1'b0}};
			acc_wr_r <= 1'b0;
			wdata_r <= 8'h00;
			dev_rdata_o <= 8'h00;
			dev_rdata_valid_o <= 1'b0;
			host_port_request_o <= 1'b0;
			host_output_latch_strobe_o <= 1'b0;
			ale_d_r <= 1'b0;
			rd_d_r <= 1'b1;
			wr_d_r <= 1'b1;
		end else begin
			ale_d_r <= ale;
			rd_d_r <= rd_n;
			wr_d_r <= wr_n;
			dev_rdata_valid_o <= 1'b0;
			host_output_latch_strobe_o <= 1'b0;
			if (!dreq_n)
				dev_pend_r <= 1'b1;
			if (host_port_request_o && ack)
				host_port_request_o <= 1'b0;
			case (st_r)
			ST_IDLE: begin
				if (dev_go || host_go) begin
					port_dev_r <= dev_go;
					acc_wr_r <= go_wr;
					acc_addr_r <= go_wr ? wr_ptr_r : rd_ptr_r;
					st_r <= extended ? ST_HI : ST_ACC;
					if (dev_go)
						dev_pend_r <= !dreq_n;
				end
			end
			ST_HI: begin
				st_r <= ST_ACC;
			end
			ST_ACC: begin
				st_r <= ST_IDLE;
				if (port_dev_r && !acc_wr_r) begin
					dev_rdata_o <= buf_rdata_i;
					dev_rdata_valid_o <= 1'b1;
				end
				if (!port_dev_r) begin
					host_port_request_o <= 1'b1;
					host_output_latch_strobe_o <= !acc_wr_r;
				end
			end
			default: st_r <= ST_IDLE;
			endcase
			if (st_r == ST_IDLE && (dev_go || host_go))
				wdata_r <= ff_data;
			// any dmacon write drops a device request left pending once the synced request pin is high
			if (wr_pulse && addr_r == `DPCB_A_DMACON && dreq_n)
				dev_pend_r <= 1'b0;
		end
	end
	// -------------------------------------------------
	// buffer pins
	// -------------------------------------------------
	always @* begin
		buf_addr_o = acc_addr_r[7:0];
		buf_addr_hi_o = acc_addr_r[11:8];
		host_upper_addr_strobe_o = acc_addr_r[8];
		device_upper_addr_strobe_o = acc_addr_r[9];
		host_upper_addr_enable_n_o = acc_addr_r[12];
		device_upper_addr_enable_n_o = acc_addr_r[13];
		buffer_mem_select_n_o = !fin;
		buf_we_n_o = !(fin && acc_wr_r);
		if (extended) begin
			host_upper_addr_strobe_o = 1'b0;
			device_upper_addr_strobe_o = 1'b0;
			host_upper_addr_enable_n_o = !(fin && !port_dev_r);
			device_upper_addr_enable_n_o = !(fin && port_dev_r);
			if (st_r == ST_HI) begin
				buf_addr_o = acc_addr_r[15:8];
				host_upper_addr_strobe_o = !port_dev_r;
				device_upper_addr_strobe_o = port_dev_r;
			end
		end else if (!amod_r) begin
			buf_addr_hi_o[3:2] = 2'b00;
			host_upper_addr_enable_n_o = 1'b0;
			device_upper_addr_enable_n_o = 1'b0;
		end
	end
	// ext holding latch data comes from the device fifo head
	wire [7:0] unused_w = wdata_r;
	// -------------------------------------------------
	// register port and counters
	// -------------------------------------------------
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			addr_r <= `DPCB_RST_BYTE;
			ifcon_r <= `DPCB_RST_BYTE;
			dmacon_r <= `DPCB_RST_BYTE;
			bufsz_r <= `DPCB_RST_BYTE;
			amod_r <= 1'b0;
			reset_control_register_r <= 1'b1;
			rd_ptr_r <= {AW{1'b0}};
			wr_ptr_r <= {AW{1'b0}};
			stop_r <= {AW{1'b0}};
			arb_seen_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			if (ale_d_r && !ale)
				addr_r <= ad2_r;
			if (fin && acc_wr_r)
				wr_ptr_r <= bump(wr_ptr_r, size_last);
			if (fin && !acc_wr_r)
				rd_ptr_r <= bump(rd_ptr_r, size_last);
			if (ifcon_r[`DPCB_IF_ARB] && !sel_in && !bsy_in)
				arb_seen_r <= 1'b1;
			else if (!ifcon_r[`DPCB_IF_ARB])
				arb_seen_r <= 1'b0;
			if (at_stop && !host_port_request_o && !ack
				&& (up_en || dn_en))
				done_r <= 1'b1;
			if (wr_pulse) begin
				case (addr_r)
				`DPCB_A_IFCON: ifcon_r <= ad2_r;
				`DPCB_A_DMACON: dmacon_r <= ad2_r;
				`DPCB_A_BUFSZ: bufsz_r <= ad2_r;
				`DPCB_A_AMOD: amod_r <= ad2_r[0];
				`DPCB_A_RESET_CONTROL_REGISTER: reset_control_register_r <= ad2_r[0];
				`DPCB_A_RDL: rd_ptr_r[7:0] <= ad2_r;
				`DPCB_A_RDH: rd_ptr_r[15:8] <= ad2_r;
				`DPCB_A_WRL: wr_ptr_r[7:0] <= ad2_r;
				`DPCB_A_WRH: wr_ptr_r[15:8] <= ad2_r;
				`DPCB_A_STL: begin
					stop_r[7:0] <= ad2_r;
					done_r <= 1'b0;
				end
				`DPCB_A_STH: begin
					stop_r[15:8] <= ad2_r;
					done_r <= 1'b0;
				end
				default: ;
				endcase
			end
		end
	end
	always @(posedge sys_clk_i) begin
		if (!rst_n_i)
			ad_o <= 8'h00;
		else begin
			case (addr_r)
			`DPCB_A_IFCON: ad_o <= {ifcon_r[7:6], bsy_in, sel_in,
				ifcon_r[3:2], 1'b0, arb_seen_r};
			`DPCB_A_DMACON: ad_o <= {dmacon_r[7:6], done_r,
				dmacon_r[4:2], ack, 1'b0};
			`DPCB_A_BUFSZ: ad_o <= bufsz_r;
			`DPCB_A_RDL: ad_o <= rd_ptr_r[7:0];
			`DPCB_A_RDH: ad_o <= rd_ptr_r[15:8];
			`DPCB_A_WRL: ad_o <= wr_ptr_r[7:0];
			`DPCB_A_WRH: ad_o <= wr_ptr_r[15:8];
			`DPCB_A_STL: ad_o <= stop_r[7:0];
			`DPCB_A_STH: ad_o <= stop_r[15:8];
			default: ad_o <= 8'h00;
			endcase
		end
	end
	assign ad_oe_o = rd_active;
	// -------------------------------------------------
	// bus arbitration and identify pins
	// -------------------------------------------------
	wire ext_acc = cs && (addr_r == `DPCB_A_EXT0 || addr_r == `DPCB_A_EXT1);
	wire host_dma = host_port_request_o;
	assign busy_out_o = ifcon_r[`DPCB_IF_BSYO] || arb_seen_r;
	assign select_out_o = ifcon_r[`DPCB_IF_SELO];
	assign host_output_drive_enable_n_o = !(arb_seen_r
		|| (ifcon_r[`DPCB_IF_BOE] && ext_acc && !wr_n)
		|| (host_dma && dir_out));
	assign host_input_drive_enable_n_o = !((ifcon_r[`DPCB_IF_BIE]
		&& ext_acc && !rd_n) || (dn_en && !port_dev_r
		&& st_r != ST_IDLE));
	assign target_identify_out_n_o = !dmacon_r[`DPCB_DM_TGT];
	assign initiator_identify_out_n_o = !dmacon_r[`DPCB_DM_INIT];
	assign dma_done_o = done_r;
endmodule

// ===== core/dpcb_fifo.v
/*
 * small flip-flop fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module dpcb_fifo #(
	parameter W = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire sys_clk_i, // master clock
	input wire rst_n_i, // sync reset, low
	input wire in_valid_i, // write offered
	output wire in_ready_o, // room available
	input wire [W-1:0] in_data_i, // write data
	output wire out_valid_o, // data available
	input wire out_ready_i, // reader takes
	output wire [W-1:0] out_data_o // head data
);
	reg [W-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wp_r;
	reg [AW-1:0] rp_r;
	reg [AW:0] cnt_r;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = (cnt_r != DEPTH);
	assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
	assign out_data_o = mem_r[rp_r];
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			wp_r <= {AW{1'b0}};
			rp_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem_r[wp_r] <= in_data_i;
				wp_r <= wp_r + 1'b1;
			end
			if (pop)
				rp_r <= rp_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// ===== core/dpcb_regs.vh
/*
 * constants for the dual port circular buffer controller: register
 * addresses, field positions, reset values and size limits.
 * assumes it is included by its bare name from core/ design files.
 */
`ifndef DPCB_REGS_VH
`define DPCB_REGS_VH
`define DPCB_A_IFCON 8'h52
`define DPCB_A_DMACON 8'h53
`define DPCB_A_BUFSZ 8'h54
`define DPCB_A_AMOD 8'h55
`define DPCB_A_RESET_CONTROL_REGISTER 8'h59
`define DPCB_A_RDL 8'h5A
`define DPCB_A_RDH 8'h5B
`define DPCB_A_WRL 8'h5C
`define DPCB_A_WRH 8'h5D
`define DPCB_A_STL 8'h5E
`define DPCB_A_STH 8'h5F
`define DPCB_A_EXT0 8'h50
`define DPCB_A_EXT1 8'h51
`define DPCB_IF_ARB 0
`define DPCB_IF_BIE 2
`define DPCB_IF_BOE 3
`define DPCB_IF_SELO 6
`define DPCB_IF_BSYO 7
`define DPCB_DM_WRL 2
`define DPCB_DM_RDL 3
`define DPCB_DM_DIR 4
`define DPCB_DM_INIT 6
`define DPCB_DM_TGT 7
`define DPCB_RST_BYTE 8'h00
`define DPCB_RES_SET 8'h01
`define DPCB_DIR10_MAX 8'h03
`define DPCB_DIR14_MAX 8'h3F
`define DPCB_FIFO_DEPTH 16
`define DPCB_FIFO_AW 4
`define DPCB_SYNC_IDLE 8'h83
`endif
